// File: src/ahb_peripheral_bridge_dma_arbiter.sv
/*
 system bus slave bridging to the hclk_peripheral_bus, with a chained
 sixteen-channel dma engine sharing that bus through an arbiter.
 assumes ahb-lite master on i_h*, apb-style slaves answering on i_pready,
 nand requests generated on i_clk.
*/
`timescale 1ns/1ns
module ahb_peripheral_bridge_dma_arbiter #(
   parameter int CHANNELS  = 16,
   parameter int NAND_CH   = 8,
   parameter int DSC_DEPTH = 64,
   localparam int CH_W     = $clog2(CHANNELS),
   localparam int BW       = CH_W + bridge_pkg::HD_W
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_rst_n,
   input  wire logic                         i_ce,
   input  wire logic                         i_hsel,
   input  wire logic [31:0]                  i_haddr,
   input  wire logic [1:0]                   i_htrans,
   input  wire logic                         i_hwrite,
   input  wire logic [bridge_pkg::HD_W-1:0]  i_hwdata,
   input  wire logic                         i_hready,
   output logic      [bridge_pkg::HD_W-1:0]  o_hrdata,
   output logic                              o_hready,
   output logic                              o_hresp,
   output logic                              o_psel,
   output logic                              o_penable,
   output logic                              o_pwrite,
   output logic      [bridge_pkg::PA_W-1:0]  o_paddr,
   output logic      [bridge_pkg::HD_W-1:0]  o_pwdata,
   input  wire logic [bridge_pkg::HD_W-1:0]  i_prdata,
   input  wire logic                         i_pready,
   input  wire logic [NAND_CH-1:0]           i_nand_req,
   input  wire logic                         i_start_vld,
   input  wire logic [CH_W-1:0]              i_start_ch,
   input  wire logic [bridge_pkg::IDX_W-1:0] i_start_head,
   input  wire logic                         i_desc_we,
   input  wire logic [bridge_pkg::IDX_W-1:0] i_desc_addr,
   input  wire logic [bridge_pkg::DSC_W-1:0] i_desc_data,
   output logic      [CHANNELS-1:0]          o_chan_active,
   output logic      [CHANNELS-1:0]          o_chan_done,
   output logic                              o_dma_vld,
   output logic      [CH_W-1:0]              o_dma_ch,
   output logic      [bridge_pkg::HD_W-1:0]  o_dma_data,
   input  wire logic                         i_dma_rdy
);
   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   bridge_pkg::bus_st_t           st;
   logic                          a_vld;
   logic                          cpu_pend;
   logic                          cpu_wr;
   logic [bridge_pkg::PA_W-1:0]   cpu_addr;
   logic [bridge_pkg::HD_W-1:0]   cpu_wdata;
   logic                          own_cpu;
   logic [1:0]                    lock;
   logic [CHANNELS-1:0]           active;
   logic [bridge_pkg::IDX_W-1:0]  cur [CHANNELS];
   logic [bridge_pkg::DSC_W-1:0]  dsc_mem [DSC_DEPTH];
   logic [CH_W-1:0]               rr;
   logic [CH_W-1:0]               dsc_ch;
   logic                          dsc_last;
   logic [bridge_pkg::IDX_W-1:0]  dsc_next;
   logic [CHANNELS-1:0]           chan_ok;
   logic [CH_W:0]                 pick;
   logic [CH_W-1:0]               sel;
   logic                          dma_want;
   logic                          grant_cpu;
   logic                          xfer_done;
   logic [bridge_pkg::DSC_W-1:0]  cur_dsc;
   fifo_if #(.W(BW)) fifo ();
   // round-robin search so a busy nand channel cannot starve the rest
   function automatic logic [CH_W:0] pick_ch(input logic [CHANNELS-1:0] m,
                                             input logic [CH_W-1:0] s);
      logic [CH_W-1:0] j;
      logic [CH_W:0]   r;
      r = '0;
      for (int i = CHANNELS - 1; i >= 0; i--) begin
         j = s + CH_W'(i);
         if (m[j]) begin
            r = {1'b1, j};
         end
      end
      return r;
   endfunction
   // ----------------------------------------------------------
   // channel qualification and arbitration terms
   // ----------------------------------------------------------
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         chan_ok[c] = active[c] & ((c < NAND_CH) ? i_nand_req[c % NAND_CH] : 1'b1);
      end
   end
   assign pick      = pick_ch(chan_ok, rr);
   assign sel       = pick[CH_W-1:0];
   assign cur_dsc   = dsc_mem[cur[sel]];
   // dma waits for buffer room, so a read always has a slot on completion
   assign dma_want  = pick[CH_W] & fifo.in_ready;
   assign grant_cpu = cpu_pend & (~dma_want | (lock == bridge_pkg::LOCK_MAX));
   assign xfer_done = (st == bridge_pkg::ST_ACCESS) & i_pready;
   // ----------------------------------------------------------
   // system bus slave
   // ----------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         a_vld     <= 1'b0;
         cpu_pend  <= 1'b0;
         cpu_wr    <= 1'b0;
         cpu_addr  <= '0;
         cpu_wdata <= '0;
         o_hready  <= 1'b1;
         o_hrdata  <= '0;
         o_hresp   <= 1'b0;
      end else if (i_ce) begin
         if (i_hsel & i_htrans[bridge_pkg::HTRANS_ACT_BIT] & i_hready & o_hready) begin
            a_vld    <= 1'b1;
            cpu_addr <= i_haddr[bridge_pkg::PA_W-1:0];
            cpu_wr   <= i_hwrite;
            o_hready <= 1'b0;
         end
         if (a_vld) begin
            a_vld     <= 1'b0;
            cpu_pend  <= 1'b1;
            cpu_wdata <= i_hwdata;
         end
         if (xfer_done & own_cpu) begin
            cpu_pend <= 1'b0;
            o_hready <= 1'b1;
            o_hrdata <= i_prdata;
         end
      end
   end

   // ----------------------------------------------------------
   // peripheral bus sequencer, same clock as the system bus
   // ----------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st        <= bridge_pkg::ST_IDLE;
         own_cpu   <= 1'b0;
         o_psel    <= 1'b0;
         o_penable <= 1'b0;
         o_pwrite  <= 1'b0;
         o_paddr   <= '0;
         o_pwdata  <= '0;
         dsc_ch    <= '0;
         dsc_last  <= 1'b0;
         dsc_next  <= '0;
      end else if (i_ce) begin
         case (st)
            bridge_pkg::ST_IDLE: begin
               if (dma_want | cpu_pend) begin
                  st      <= bridge_pkg::ST_SETUP;
                  o_psel  <= 1'b1;
                  own_cpu <= grant_cpu;
                  if (grant_cpu) begin
                     o_paddr  <= cpu_addr;
                     o_pwrite <= cpu_wr;
                     o_pwdata <= cpu_wdata;
                  end else begin
                     o_paddr  <= cur_dsc[bridge_pkg::DSC_ADDR_LSB +: bridge_pkg::PA_W];
                     o_pwrite <= cur_dsc[bridge_pkg::DSC_WR_BIT];
                     o_pwdata <= cur_dsc[bridge_pkg::DSC_DATA_LSB +: bridge_pkg::HD_W];
                     dsc_ch   <= sel;
                     dsc_last <= cur_dsc[bridge_pkg::DSC_LAST_BIT];
                     dsc_next <= cur_dsc[bridge_pkg::DSC_NEXT_LSB +: bridge_pkg::IDX_W];
                  end
               end
            end
            bridge_pkg::ST_SETUP: begin
               o_penable <= 1'b1;
               st        <= bridge_pkg::ST_ACCESS;
            end
            bridge_pkg::ST_ACCESS: begin
               if (i_pready) begin
                  o_psel    <= 1'b0;
                  o_penable <= 1'b0;
                  st        <= bridge_pkg::ST_IDLE;
               end
            end
            default: begin
               o_psel    <= 1'b0;
               o_penable <= 1'b0;
               st        <= bridge_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // lockout counter
   // ----------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         lock <= bridge_pkg::LOCK_RST;
      end else if (i_ce && st == bridge_pkg::ST_IDLE && (dma_want | cpu_pend)) begin
         if (grant_cpu) begin
            lock <= bridge_pkg::LOCK_RST;
         end else if (cpu_pend) begin
            lock <= lock + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------
   // descriptor store and channel chains
   // ----------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_ce && i_desc_we) begin
         dsc_mem[i_desc_addr] <= i_desc_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         active      <= '0;
         o_chan_done <= '0;
         rr          <= '0;
         for (int c = 0; c < CHANNELS; c++) begin
            cur[c] <= '0;
         end
      end else if (i_ce) begin
         o_chan_done <= '0;
         if (xfer_done & ~own_cpu) begin
            cur[dsc_ch] <= dsc_next;
            rr          <= dsc_ch + CH_W'(1);
            if (dsc_last) begin
               active[dsc_ch]      <= 1'b0;
               o_chan_done[dsc_ch] <= 1'b1;
            end
         end
         // a restart wins over the chain end of the same channel
         if (i_start_vld) begin
            active[i_start_ch] <= 1'b1;
            cur[i_start_ch]    <= i_start_head;
         end
      end
   end
   assign o_chan_active = active;
   // ----------------------------------------------------------
   // read data out through the buffer
   // ----------------------------------------------------------
   assign fifo.in_valid  = xfer_done & ~own_cpu & ~o_pwrite;
   assign fifo.in_data   = {dsc_ch, i_prdata};
   assign fifo.out_ready = i_dma_rdy;
   assign o_dma_vld      = fifo.out_valid;
   assign o_dma_ch       = fifo.out_data[BW-1 -: CH_W];
   assign o_dma_data     = fifo.out_data[bridge_pkg::HD_W-1:0];
   two_entry_buf #(.W(BW)) u_buf (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .bus     (fifo)
   );

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n || !i_ce);
   a_penable_in_sel: assert property (o_penable |-> o_psel)
      else $error("enable without select");
   a_pio_addr_match: assert property (o_psel && own_cpu |-> o_paddr == cpu_addr)
      else $error("bridge address not forwarded");
   a_setup_to_access: assert property (st == bridge_pkg::ST_SETUP |=> st == bridge_pkg::ST_ACCESS && $stable(o_paddr) && $stable(own_cpu))
      else $error("owner or address moved mid transfer");
   a_dma_favoured: assert property (st == bridge_pkg::ST_IDLE && dma_want && cpu_pend && lock != bridge_pkg::LOCK_MAX |=> !own_cpu && o_psel)
      else $error("dma not favoured");
   a_hready_waits: assert property (cpu_pend |-> !o_hready)
      else $error("hready high while bridge transfer waits");
   a_hready_release: assert property (xfer_done && own_cpu |=> o_hready && o_hrdata == $past(i_prdata))
      else $error("hready not released on completion");
   a_fourth_grant: assert property (st == bridge_pkg::ST_IDLE && cpu_pend && lock == bridge_pkg::LOCK_MAX |=> own_cpu && st == bridge_pkg::ST_SETUP)
      else $error("processor not granted after lockouts");
   a_lock_cleared: assert property (st == bridge_pkg::ST_IDLE && cpu_pend && grant_cpu |=> lock == bridge_pkg::LOCK_RST)
      else $error("lockout count not cleared");
   a_chain_keeps: assert property (xfer_done && !own_cpu && !dsc_last && !i_start_vld |=> active[$past(dsc_ch)] && cur[$past(dsc_ch)] == $past(dsc_next))
      else $error("chain did not advance");
   a_nand_gated: assert property (st == bridge_pkg::ST_IDLE && dma_want && !grant_cpu && sel < CH_W'(NAND_CH) |-> i_nand_req[sel[$clog2(NAND_CH)-1:0]])
      else $error("nand channel ran without request");

   c_cpu_after_lock: cover property (lock == bridge_pkg::LOCK_MAX && cpu_pend ##1 own_cpu);
   c_dma_read_out:   cover property (fifo.in_valid ##[1:4] o_dma_vld && i_dma_rdy);
   c_buf_full:       cover property (!fifo.in_ready && !i_dma_rdy);
   c_chain_end:      cover property (|o_chan_done);
endmodule

// File: src/bridge_pkg.sv
/*
 shared constants for the peripheral bridge with dma arbiter.
 assumes a single system clock for both buses.
*/
package bridge_pkg;
   // ----------------------------------------------------------
   // bus widths
   // ----------------------------------------------------------
   localparam int HD_W            = 32;
   localparam int PA_W            = 16;
   localparam int HTRANS_ACT_BIT  = 1;
   // ----------------------------------------------------------
   // descriptor layout: data, periph addr, write, last, next
   // ----------------------------------------------------------
   localparam int IDX_W           = 6;
   localparam int DSC_W           = 56;
   localparam int DSC_DATA_LSB    = 0;
   localparam int DSC_ADDR_LSB    = 32;
   localparam int DSC_WR_BIT      = 48;
   localparam int DSC_LAST_BIT    = 49;
   localparam int DSC_NEXT_LSB    = 50;
   // ----------------------------------------------------------
   // arbiter
   // ----------------------------------------------------------
   localparam logic [1:0] LOCK_MAX = 2'h3;
   localparam logic [1:0] LOCK_RST = 2'h0;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h1,
      ST_SETUP  = 3'h2,
      ST_ACCESS = 3'h4
   } bus_st_t;
endpackage

// File: src/fifo_if.sv
/*
 valid/ready carrier between the dma engine and its output buffer.
 assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
interface fifo_if #(parameter int W = 36);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport buf_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// File: src/two_entry_buf.sv
/*
 two-entry buffer, all outputs registered.
 assumes the filler honours in_ready; a stalled drain backs up to it.
*/
`timescale 1ns/1ns
module two_entry_buf #(
   parameter int W = 36
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   fifo_if.buf_side  bus
);
   logic [W-1:0] head;
   logic [W-1:0] spare;
   logic         head_v;
   logic         spare_v;
   logic         push;
   logic         pop;

   assign push          = bus.in_valid & bus.in_ready;
   assign pop           = head_v & bus.out_ready;
   assign bus.out_valid = head_v;
   assign bus.out_data  = head;
   assign bus.in_ready  = ~spare_v;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         head_v  <= 1'b0;
         spare_v <= 1'b0;
         head    <= '0;
         spare   <= '0;
      end else if (i_ce) begin
         if (pop) begin
            if (spare_v) begin
               head    <= spare;
               spare_v <= 1'b0;
            end else if (push) begin
               head <= bus.in_data;
            end else begin
               head_v <= 1'b0;
            end
         end else if (push) begin
            if (head_v) begin
               spare   <= bus.in_data;
               spare_v <= 1'b1;
            end else begin
               head   <= bus.in_data;
               head_v <= 1'b1;
            end
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n || !i_ce);
   a_buf_hold_data: assert property (head_v && !bus.out_ready |=> head_v && $stable(head))
      else $error("buffer head changed while stalled");
endmodule

// File: verification/periph_model.sv
/*
 peripheral slave model: sixteen words answered on the peripheral bus.
 assumes the bridge drives the select/enable pair on i_clk.
*/
`timescale 1ns/1ns
module periph_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [15:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [1:0]  i_wait,
   output logic      [31:0] o_prdata,
   output logic             o_pready
);
   logic [31:0] mem [0:15];
   logic [31:0] last_rd;
   logic [1:0]  waited;
   logic        acc_done;
   int          i;
   // ---------------------------------------------
   // answer
   // ---------------------------------------------
   assign o_pready = i_psel & i_penable & (waited == i_wait);
   assign acc_done = o_pready;
   // released bus shows the inverse of the last word, never a stale copy
   assign o_prdata = (acc_done & !i_pwrite) ? mem[i_paddr[5:2]] : ~last_rd;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         waited  <= 2'h0;
         last_rd <= 32'h0000_0000;
         for (i = 0; i < 16; i++) begin
            mem[i] <= 32'h5a5a_0000 + i;
         end
      end else begin
         waited <= (i_psel & i_penable & !o_pready) ? waited + 2'h1 : 2'h0;
         if (acc_done & i_pwrite) begin
            mem[i_paddr[5:2]] <= i_pwdata;
         end
         if (acc_done & !i_pwrite) begin
            last_rd <= mem[i_paddr[5:2]];
         end
      end
   end
endmodule

// File: verification/tb_ahb_peripheral_bridge_dma_arbiter.sv
/*
 self-checking bench for the bridge with dma arbiter.
 assumes periph_model as the only peripheral; inputs change on falling edges.
*/
`timescale 1ns/1ns
module tb_ahb_peripheral_bridge_dma_arbiter;
   logic        i_clk, i_rst_n, i_ce, i_hsel, i_hwrite, i_start_vld, i_desc_we, i_dma_rdy;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, o_pwdata, prdata, o_dma_data, rd;
   logic [1:0]  i_htrans, p_wait;
   logic        o_hready, o_hresp, o_psel, o_penable, o_pwrite, pready, o_dma_vld;
   logic [15:0] o_paddr, o_chan_active, o_chan_done;
   logic [7:0]  i_nand_req;
   logic [3:0]  i_start_ch, o_dma_ch;
   logic [5:0]  i_start_head, i_desc_addr;
   logic [55:0] i_desc_data;
   int          n_errors, checks_done, dma_setups, any_setups, done_pulses, w, d;

   ahb_peripheral_bridge_dma_arbiter dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hwdata(i_hwdata), .i_hready(1'b1), .o_hrdata(o_hrdata), .o_hready(o_hready),
      .o_hresp(o_hresp), .o_psel(o_psel), .o_penable(o_penable), .o_pwrite(o_pwrite),
      .o_paddr(o_paddr), .o_pwdata(o_pwdata), .i_prdata(prdata), .i_pready(pready),
      .i_nand_req(i_nand_req), .i_start_vld(i_start_vld), .i_start_ch(i_start_ch),
      .i_start_head(i_start_head), .i_desc_we(i_desc_we), .i_desc_addr(i_desc_addr),
      .i_desc_data(i_desc_data), .o_chan_active(o_chan_active), .o_chan_done(o_chan_done),
      .o_dma_vld(o_dma_vld), .o_dma_ch(o_dma_ch), .o_dma_data(o_dma_data),
      .i_dma_rdy(i_dma_rdy));
   periph_model peri (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(o_psel),
      .i_penable(o_penable), .i_pwrite(o_pwrite), .i_paddr(o_paddr), .i_pwdata(o_pwdata),
      .i_wait(p_wait), .o_prdata(prdata), .o_pready(pready));

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   // setup cycles seen on the peripheral bus
   always @(posedge i_clk) begin
      if (o_psel === 1'b1 && o_penable === 1'b0) any_setups++;
      if (o_psel === 1'b1 && o_penable === 1'b0 && o_paddr === 16'h0020) dma_setups++;
      if (o_chan_done[15] === 1'b1) done_pulses++;
   end
   // ---------------------------------------------
   // checks and bus tasks
   // ---------------------------------------------
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      chk_word({31'h0000_0000, got}, {31'h0000_0000, exp}, m);
   endtask
   task automatic chk_in(input int got, input int lo, input int hi, input string m);
      checks_done++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("wrong value at %0t: %s count %0d", $time, m, got);
      end
   endtask
   task automatic stuck();
      n_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      end_of_test();
   endtask
   task automatic do_reset();
      @(negedge i_clk);
      i_rst_n = 1'b0;
      repeat (3) @(negedge i_clk);
      i_rst_n = 1'b1;
   endtask
   // one transfer; w = wait cycles, d = dma setups while the cpu waited
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int base;
      @(negedge i_clk);
      i_hsel = 1'b1; i_htrans = 2'h2; i_hwrite = wr; i_haddr = a;
      @(negedge i_clk);
      i_hsel = 1'b0; i_htrans = 2'h0; i_hwdata = wd;
      w = 0;
      base = dma_setups;
      while (o_hready !== 1'b1) begin
         if (w == 2) base = dma_setups;
         if (w == 300) stuck();
         @(negedge i_clk);
         w++;
      end
      d = dma_setups - base;
      rd = o_hrdata;
   endtask
   task automatic put_desc(input int idx, input logic [31:0] dat, input logic [15:0] pa,
                           input logic wr, input logic last, input logic [5:0] nxt);
      @(negedge i_clk);
      i_desc_we = 1'b1; i_desc_addr = idx[5:0]; i_desc_data = {nxt, last, wr, pa, dat};
      @(negedge i_clk);
      i_desc_we = 1'b0;
   endtask
   task automatic start(input logic [3:0] ch, input logic [5:0] head);
      @(negedge i_clk);
      i_start_vld = 1'b1; i_start_ch = ch; i_start_head = head;
      @(negedge i_clk);
      i_start_vld = 1'b0;
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_pio();
      chk_bit(o_hready, 1'b1, "idle hready");
      p_wait = 2'h0;
      ahb(1'b1, 32'h0000_0010, 32'hcafe_0001);
      chk_in(w, 4, 4, "write wait states");
      p_wait = 2'h3;
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
      chk_word(rd, 32'hcafe_0001, "read back");
      chk_in(w, 7, 7, "slow peripheral wait");
      chk_bit(o_hresp, 1'b0, "response okay");
      p_wait = 2'h0;
      $display("test pio done");
   endtask
   task automatic t_chain();
      int k;
      i_dma_rdy = 1'b0;
      put_desc(0, 32'h0, 16'h0004, 1'b0, 1'b0, 6'h01);
      put_desc(1, 32'h0, 16'h0008, 1'b0, 1'b0, 6'h02);
      put_desc(2, 32'h0, 16'h000c, 1'b0, 1'b1, 6'h00);
      done_pulses = 0;
      start(4'hf, 6'h00);
      repeat (30) @(negedge i_clk);
      // buffer holds two words, the third descriptor must be held back
      chk_bit(o_chan_active[15], 1'b1, "stalled channel active");
      for (k = 1; k < 4; k++) begin
         w = 0;
         while (o_dma_vld !== 1'b1) begin
            if (w == 100) stuck();
            @(negedge i_clk);
            w++;
         end
         chk_word(o_dma_data, 32'h5a5a_0000 + k, "chained word");
         chk_word({28'h0, o_dma_ch}, 32'h0000_000f, "channel tag");
         i_dma_rdy = 1'b1;
         @(negedge i_clk);
         i_dma_rdy = 1'b0;
         @(negedge i_clk);
      end
      repeat (5) @(negedge i_clk);
      chk_bit(o_chan_active[15], 1'b0, "chain ended");
      chk_in(done_pulses, 1, 1, "done pulses");
      i_dma_rdy = 1'b1;
      $display("test chain done");
   endtask
   task automatic t_gate();
      int base;
      put_desc(20, 32'h0, 16'h0014, 1'b0, 1'b1, 6'h00);
      base = any_setups;
      start(4'h3, 6'h14);
      repeat (20) @(negedge i_clk);
      chk_in(any_setups - base, 0, 0, "gated channel quiet");
      chk_bit(o_chan_active[3], 1'b1, "gated channel active");
      i_nand_req[3] = 1'b1;
      i_ce = 1'b0;
      repeat (10) @(negedge i_clk);
      chk_in(any_setups - base, 0, 0, "frozen by clock enable");
      i_ce = 1'b1;
      repeat (20) @(negedge i_clk);
      chk_in(any_setups - base, 1, 1, "released channel ran");
      chk_bit(o_chan_active[3], 1'b0, "released channel ended");
      $display("test gate done");
   endtask
   task automatic t_arb();
      put_desc(10, 32'h1234_5678, 16'h0020, 1'b1, 1'b0, 6'h0a);
      start(4'h9, 6'h0a);
      repeat (10) @(negedge i_clk);
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
      chk_word(rd, 32'hcafe_0001, "read under contention");
      chk_in(d, 1, 3, "dma grants before cpu");
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
      chk_in(d, 1, 3, "dma favoured again");
      do_reset();
      $display("test arbitration done");
   endtask

   initial begin
      n_errors = 0; checks_done = 0; dma_setups = 0; any_setups = 0; done_pulses = 0;
      i_rst_n = 1'b0; i_hsel = 1'b0; i_hwrite = 1'b0; i_htrans = 2'h0;
      i_haddr = 32'h0000_0000; i_hwdata = 32'h0000_0000; p_wait = 2'h0;
      i_nand_req = 8'h00; i_start_vld = 1'b0; i_start_ch = 4'h0; i_start_head = 6'h00;
      i_desc_we = 1'b0; i_desc_addr = 6'h00; i_desc_data = 56'h0; i_dma_rdy = 1'b1;
      i_ce = 1'b1;
      do_reset();
      chk_bit(o_psel, 1'b0, "reset select");
      chk_word({o_chan_active, 15'h0, o_dma_vld}, 32'h0000_0000, "reset dma");
      t_pio();
      t_chain();
      t_gate();
      t_arb();
      chk_bit(o_hready, 1'b1, "hready after reset");
      end_of_test();
   end
endmodule
